// ---- ivs_top.v ----
// Interrupt vector selector top: flags, enables, levels, bus slave.
// Assumes classic Wishbone master and a core that fetches the
// vector word from program memory over the fetch port.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "ivs_map.vh"
// Function
// - Merge all requests into one core request
// - Each user source gets a selectable priority level
// - Same level resolved by fixed index order
// - Primary table at 000004h, 126 entries
// - Each entry yields a 24-bit routine address
// - Lower table position outranks higher position at equal level
// - Traps ignore enables and priority settings
// - Every source owns a distinct entry
// - Fixed entry and return cycle counts
// - Select bit switches to alternate table
// - Alternate table follows primary, same layout
// - Reset bypasses controller; start at zero
// - Hardware sets flags, software clears them
// - Per-source enable gates forwarding
// - Latch pending index and level readable
// - Cpu level seven blocks user interrupts
module ivs_top #(
  parameter NTRAP = `IVS_NUM_TRAPS,         // Trap count
  parameter NIRQ  = `IVS_NUM_IRQS           // User source count
) (
  input  wire             clk_in,           // System clock
  input  wire             rst_b_in,         // Sync reset, low
  input  wire [NTRAP-1:0] trap_in,          // Trap event pulses
  input  wire [NIRQ-1:0]  irq_in,           // Source event pulses
  input  wire             ack_core_in,      // Core starts entry
  input  wire             ret_core_in,      // Core returns
  input  wire [23:0]      fetch_data_in,    // Word read at fetch addr
  output wire             irq_out,          // Request to core
  output reg  [23:0]      fetch_addr_out,   // Slot address to read
  output reg              fetch_out,        // Slot read strobe
  output reg  [23:0]      isr_addr_out,     // Routine start address
  output reg              isr_valid_out,    // Routine addr pulse
  output reg  [23:0]      reset_pc_out,     // Pc value after reset
  output reg              ret_done_out,     // Return finished pulse
  input  wire             wb_cyc_i,         // Wishbone cycle
  input  wire             wb_stb_i,         // Wishbone strobe
  input  wire             wb_we_i,          // Wishbone write
  input  wire [7:0]       wb_adr_i,         // Byte address
  input  wire [3:0]       wb_sel_i,         // Byte lanes
  input  wire [31:0]      wb_dat_i,         // Write data
  output reg  [31:0]      wb_dat_o,         // Read data
  output reg              wb_ack_o          // Acknowledge
);
  // One-hot entry sequencer states
  localparam ST_IDLE  = 4'b0001;
  localparam ST_FETCH = 4'b0010;
  localparam ST_LOAD  = 4'b0100;
  localparam ST_RET   = 4'b1000;

  reg  [15:0]     ctrl_q;                   // Control two register
  reg  [2:0]      cpu_pl_q;                 // Cpu level field
  reg  [NIRQ-1:0] flag_q;                   // Request flags
  reg  [NIRQ-1:0] en_q;                     // Enables
  reg  [3*NIRQ-1:0] lvl_q;                  // Priority levels
  reg  [NTRAP-1:0] trap_q;                  // Trap flags
  reg  [6:0]      sel_q;                    // Selected source index
  reg  [6:0]      vnum_q;                   // Latched vector number
  reg  [3:0]      vlvl_q;                   // Latched new level
  reg  [3:0]      st_q;                     // Sequencer state
  reg  [2:0]      cnt_q;                    // Fixed latency counter
  reg  [6:0]      serv_q;                   // Entry in service
  wire            hit;                      // Arbiter found a winner
  wire [6:0]      win_num;                  // Winner entry index
  wire [3:0]      win_lvl;                  // Winner level
  wire [23:0]     slot_addr;                // Table slot address
  wire            wb_req;                   // Bus request present
  wire            wr_go;                    // Write takes effect
  wire [NIRQ-1:0] clr_mask;                 // Software clear pulses
  wire [NTRAP-1:0] trap_clr;                // Trap clear pulses
  wire [6:0]      sel_irq;                  // Index as user source

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_go  = wb_req && wb_we_i;
  assign sel_irq = sel_q - NTRAP[6:0];

  // Byte lane merge used by the control, cpu level and select registers
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel_v;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel_v[k]) begin
          lane_merge[8*k +: 8] = new_v[8*k +: 8];
        end
      end
    end
  endfunction

  // Only forwarded requests reach the arbiter
  ivs_arbiter #(
    .NTRAP (NTRAP),
    .NIRQ  (NIRQ)
  ) u_arb (
    .trap_req_in (trap_q),
    .irq_req_in  (flag_q & en_q),
    .irq_lvl_in  (lvl_q),
    .cpu_pl_in   (cpu_pl_q),
    .hit_out     (hit),
    .win_num_out (win_num),
    .win_lvl_out (win_lvl)
  );

  ivs_vector_addr u_addr (
    .num_in   (vnum_q),
    .alt_in   (ctrl_q[`IVS_ALT_SEL_BIT]),
    .addr_out (slot_addr)
  );

  // Single request line: pending winner while the sequencer is free
  assign irq_out = hit && st_q == ST_IDLE;

  // Clear strobes from flag writes: one bit, the source index given in the write data
  genvar g;
  generate
    for (g = 0; g < NIRQ; g = g + 1) begin : g_clr
      assign clr_mask[g] = wr_go && wb_adr_i == `IVS_OFF_FLAG &&
                           wb_dat_i[31:7] == 25'h0 &&
                           wb_dat_i[6:0] == g[6:0] && wb_sel_i[0];
    end
    for (g = 0; g < NTRAP; g = g + 1) begin : g_tclr
      assign trap_clr[g] = wr_go && wb_adr_i == `IVS_OFF_TRAPS &&
                           wb_sel_i[0] && wb_dat_i[g];
    end
  endgenerate

  // Flags: hardware set wins over a software clear in the same cycle
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      flag_q <= {NIRQ{1'b0}};
      trap_q <= {NTRAP{1'b0}};
    end else begin
      flag_q <= irq_in | (flag_q & ~clr_mask);
      trap_q <= trap_in | (trap_q & ~trap_clr);
    end
  end

  // Register writes; reset loads levels with 4 and clears the rest, independent of sequencer
  always @(posedge clk_in) begin : p_regs
    reg [31:0] m;
    m = 32'h0;
    if (!rst_b_in) begin
      ctrl_q   <= `IVS_CTRL_RESET;
      cpu_pl_q <= 3'h0;
      sel_q    <= 7'h00;
      en_q     <= {NIRQ{1'b0}};
      lvl_q    <= {NIRQ{`IVS_PRIO_RESET}};
      reset_pc_out <= `IVS_RESET_ADDR;
    end else if (wr_go) begin
      if (wb_adr_i == `IVS_OFF_CTRL) begin
        m = lane_merge({16'h0, ctrl_q}, wb_dat_i, wb_sel_i);
        ctrl_q <= m[15:0];
      end else if (wb_adr_i == `IVS_OFF_CPUPL) begin
        m = lane_merge({29'h0, cpu_pl_q}, wb_dat_i, wb_sel_i);
        cpu_pl_q <= m[2:0];
      end else if (wb_adr_i == `IVS_OFF_SEL) begin
        m = lane_merge({25'h0, sel_q}, wb_dat_i, wb_sel_i);
        sel_q <= m[6:0];
      end else if (wb_adr_i == `IVS_OFF_ENABLE &&
                   sel_q >= NTRAP[6:0] &&
                   sel_q < NTRAP[6:0] + NIRQ[6:0] && wb_sel_i[0]) begin
        en_q[sel_irq] <= wb_dat_i[0];
      end else if (wb_adr_i == `IVS_OFF_PRIO &&
                   sel_q >= NTRAP[6:0] &&
                   sel_q < NTRAP[6:0] + NIRQ[6:0] && wb_sel_i[0]) begin
        lvl_q[3*sel_irq +: 3] <= wb_dat_i[2:0];
      end
    end
  end

  // Read mux and one-cycle ack; unmapped reads give zero
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `IVS_OFF_CTRL) begin
          wb_dat_o <= {16'h0, ctrl_q};
        end else if (wb_adr_i == `IVS_OFF_STATUS) begin
          wb_dat_o <= {20'h0, vlvl_q, 1'b0, vnum_q};
        end else if (wb_adr_i == `IVS_OFF_CPUPL) begin
          wb_dat_o <= {29'h0, cpu_pl_q};
        end else if (wb_adr_i == `IVS_OFF_SEL) begin
          wb_dat_o <= {25'h0, sel_q};
        end else if (wb_adr_i == `IVS_OFF_FLAG) begin
          wb_dat_o <= {31'h0, sel_q >= NTRAP[6:0] &&
                       sel_q < NTRAP[6:0] + NIRQ[6:0] &&
                       flag_q[sel_irq]};
        end else if (wb_adr_i == `IVS_OFF_ENABLE) begin
          wb_dat_o <= {31'h0, sel_q >= NTRAP[6:0] &&
                       sel_q < NTRAP[6:0] + NIRQ[6:0] &&
                       en_q[sel_irq]};
        end else if (wb_adr_i == `IVS_OFF_PRIO) begin
          wb_dat_o <= (sel_q >= NTRAP[6:0] &&
                       sel_q < NTRAP[6:0] + NIRQ[6:0]) ?
                      {29'h0, lvl_q[3*sel_irq +: 3]} : 32'h0;
        end else if (wb_adr_i == `IVS_OFF_TRAPS) begin
          wb_dat_o <= {{(32-NTRAP){1'b0}}, trap_q};
        end else begin
          wb_dat_o <= 32'h0;
        end
      end
    end
  end

  // Status latch follows the pending winner while idle
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      vnum_q <= 7'h00;
      vlvl_q <= 4'h0;
    end else if (st_q == ST_IDLE && hit) begin
      vnum_q <= win_num;
      vlvl_q <= win_lvl;
    end
  end

  // Entry sequencer: fixed cycle count from ack to routine address
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_q           <= ST_IDLE;
      cnt_q          <= 3'h0;
      serv_q         <= 7'h00;
      fetch_addr_out <= 24'h0;
      fetch_out      <= 1'b0;
      isr_addr_out   <= 24'h0;
      isr_valid_out  <= 1'b0;
      ret_done_out   <= 1'b0;
    end else begin
      fetch_out     <= 1'b0;
      isr_valid_out <= 1'b0;
      ret_done_out  <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (ack_core_in && hit) begin
            serv_q         <= vnum_q;
            fetch_addr_out <= slot_addr;
            fetch_out      <= 1'b1;
            st_q           <= ST_FETCH;
          end else if (ret_core_in) begin
            cnt_q <= 3'h0;
            st_q  <= ST_RET;
          end
        end
        ST_FETCH: begin
          st_q <= ST_LOAD;
        end
        ST_LOAD: begin
          isr_addr_out  <= fetch_data_in;
          isr_valid_out <= 1'b1;
          st_q          <= ST_IDLE;
        end
        ST_RET: begin
          // Return takes the same fixed count as entry
          if (cnt_q == 3'h1) begin
            ret_done_out <= 1'b1;
            st_q         <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- ivs_map.vh ----
// Constants for the interrupt vector selector: bus offsets, fields, resets.
// Assumes inclusion by bare name from each design file of the block.
`ifndef IVS_MAP_VH
`define IVS_MAP_VH
// Program-memory table layout
`define IVS_RESET_ADDR      24'h000000
`define IVS_PRI_BASE        24'h000004
`define IVS_ALT_BASE        24'h000104
`define IVS_NUM_ENTRIES     126
`define IVS_NUM_TRAPS       8
`define IVS_NUM_IRQS        118
`define IVS_ENTRY_STRIDE    2
// Register byte offsets on the bus
`define IVS_OFF_CTRL        8'h00
`define IVS_OFF_STATUS      8'h04
`define IVS_OFF_CPUPL       8'h08
`define IVS_OFF_SEL         8'h0c
`define IVS_OFF_FLAG        8'h10
`define IVS_OFF_ENABLE      8'h14
`define IVS_OFF_PRIO        8'h18
`define IVS_OFF_TRAPS       8'h1c
// Field position, blocking level and reset values
`define IVS_ALT_SEL_BIT     15
`define IVS_PL_BLOCKED      3'h7
`define IVS_CTRL_RESET      16'h0000
`define IVS_PRIO_RESET      3'h4
// Fixed entry latency in cycles
`define IVS_ENTRY_CYCLES    3
`endif

// ---- ivs_arbiter.v ----
// Priority resolver across traps and user interrupt sources.
// Assumes levels and request masks are stable for one cycle of clk.
`timescale 1ns/1ps
`include "ivs_map.vh"
module ivs_arbiter #(
  parameter NTRAP = 8,                      // Trap count
  parameter NIRQ  = 118                     // User source count
) (
  input  wire [NTRAP-1:0]  trap_req_in,     // Trap requests
  input  wire [NIRQ-1:0]   irq_req_in,      // Enabled user requests
  input  wire [3*NIRQ-1:0] irq_lvl_in,      // Level per source
  input  wire [2:0]        cpu_pl_in,       // Current cpu level
  output reg               hit_out,         // Something wins
  output reg  [6:0]        win_num_out,     // Entry index of winner
  output reg  [3:0]        win_lvl_out      // New level of winner
);
  integer i;                                // Scan index
  // Lowest index wins inside a level: scan downward so last hit stays
  always @* begin
    hit_out     = 1'b0;
    win_num_out = 7'h00;
    win_lvl_out = 4'h0;
    for (i = NIRQ-1; i >= 0; i = i - 1) begin
      if (irq_req_in[i] && irq_lvl_in[3*i +: 3] != 3'h0 &&
          irq_lvl_in[3*i +: 3] > cpu_pl_in &&
          cpu_pl_in != `IVS_PL_BLOCKED &&
          {1'b0, irq_lvl_in[3*i +: 3]} >= win_lvl_out) begin
        hit_out     = 1'b1;
        win_num_out = i[6:0] + NTRAP[6:0];
        win_lvl_out = {1'b0, irq_lvl_in[3*i +: 3]};
      end
    end
    // Traps outrank everything and ignore enables and levels
    for (i = NTRAP-1; i >= 0; i = i - 1) begin
      if (trap_req_in[i]) begin
        hit_out     = 1'b1;
        win_num_out = i[6:0];
        win_lvl_out = 4'h8;
      end
    end
  end
endmodule

// ---- ivs_vector_addr.v ----
// Turns an entry index and table select into a table slot address.
// Assumes index below the table size.
`timescale 1ns/1ps
`include "ivs_map.vh"
module ivs_vector_addr (
  input  wire [6:0]  num_in,                // Entry index
  input  wire        alt_in,                // Use alternate table
  output wire [23:0] addr_out               // Slot address
);
  // Base plus two per entry; alternate table shares layout
  assign addr_out = (alt_in ? `IVS_ALT_BASE : `IVS_PRI_BASE) +
                    {16'h0000, num_in, 1'b0};
endmodule

// ---- ivs_top_properties.sv ----
// Port-level checks for the vector selector top.
// Assumes one clock domain and the low synchronous reset of the top.
`timescale 1ns/1ps
module ivs_chk #(
  parameter NTRAP = 8                      // Trap count
) (
  input wire             clk_in,           // System clock
  input wire             rst_b_in,         // Sync reset, low
  input wire [NTRAP-1:0] trap_in,          // Trap events
  input wire             ack_core_in,      // Core accepts
  input wire             ret_core_in,      // Core returns
  input wire [23:0]      fetch_data_in,    // Slot word
  input wire             irq_out,          // Core request
  input wire [23:0]      fetch_addr_out,   // Slot address
  input wire             fetch_out,        // Slot strobe
  input wire [23:0]      isr_addr_out,     // Routine address
  input wire             isr_valid_out,    // Routine pulse
  input wire [23:0]      reset_pc_out,     // Pc after reset
  input wire             ret_done_out,     // Return pulse
  input wire             wb_cyc_i,         // Bus cycle
  input wire             wb_stb_i,         // Bus strobe
  input wire             wb_ack_o          // Bus acknowledge
);
  reg  [1:0] busy_q;                       // Cycles left in a sequence
  wire       take = ack_core_in && irq_out; // Entry accepted
  wire       idle = (busy_q == 2'h0);      // No sequence running
  // Shadow of the sequencer, so returns are only judged when idle
  always @(posedge clk_in) begin
    if (!rst_b_in)
      busy_q <= 2'h0;
    else if (take || (ret_core_in && idle))
      busy_q <= 2'h2;
    else if (!idle)
      busy_q <= busy_q - 2'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Entry walk: strobe, word, then routine address
  sequence s_entry;
    fetch_out ##2 isr_valid_out;
  endsequence
  chk_entry_steps: assert property (take |=> s_entry)
    else $error("entry sequence off");
  chk_vector_word: assert property (fetch_out |-> ##2
    (isr_addr_out == $past(fetch_data_in))) else $error("bad routine");
  chk_ret_latency: assert property (ret_core_in && idle && !take
    |-> ##3 ret_done_out) else $error("return late");
  chk_req_gap: assert property (take |=> !irq_out [*2])
    else $error("request during entry");
  chk_fetch_cause: assert property (fetch_out |-> $past(take))
    else $error("fetch without accept");
  chk_trap_raise: assert property ((trap_in != 0) && idle && !take
    && !ret_core_in |=> irq_out) else $error("trap masked");
  chk_slot_range: assert property (fetch_out |-> !fetch_addr_out[0]
    && fetch_addr_out >= 24'h000004 && fetch_addr_out <= 24'h0001fe)
    else $error("slot outside tables");
  chk_reset_pc: assert property (reset_pc_out == 24'h000000)
    else $error("reset pc not zero");
  chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack shape");
endmodule
bind ivs_top ivs_chk #(.NTRAP(NTRAP)) u_ivs_chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .trap_in(trap_in), .ack_core_in(ack_core_in),
  .ret_core_in(ret_core_in), .fetch_data_in(fetch_data_in),
  .irq_out(irq_out), .fetch_addr_out(fetch_addr_out),
  .fetch_out(fetch_out), .isr_addr_out(isr_addr_out),
  .isr_valid_out(isr_valid_out), .reset_pc_out(reset_pc_out),
  .ret_done_out(ret_done_out), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ---- ivs_core_model.sv ----
// Core-side partner: accepts one request on command, serves slot words.
// Assumes the selector strobes fetch one cycle before it samples data.
`timescale 1ns/1ps
module ivs_core_model (
  input  wire        clk_in,                   // System clock
  input  wire        rst_b_in,                 // Sync reset, low
  input  wire        take_in,                  // Accept one request
  input  wire        irq_in,                   // Request from selector
  input  wire        fetch_in,                 // Slot read strobe
  input  wire [23:0] fetch_addr_in,            // Slot address
  output reg         ack_out = 1'b0,           // Entry accept pulse
  output reg  [23:0] fetch_data_out = 24'h0    // Slot word
);
  reg armed_q = 1'b0;                          // One acceptance pending
  // Accept once, then let the line drop until armed again
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      armed_q        <= 1'b0;
      ack_out        <= 1'b0;
      fetch_data_out <= 24'hffffff;
    end else begin
      ack_out <= armed_q && irq_in;
      if (armed_q && irq_in)
        armed_q <= 1'b0;
      else if (take_in)
        armed_q <= 1'b1;
      // Each slot points at its own handler; alternate mirrors primary,
      // the reset slot holds the start-up jump; stale words are scrambled
      if (fetch_in && fetch_addr_in == 24'h000000)
        fetch_data_out <= 24'h000200;
      else if (fetch_in)
        fetch_data_out <= {16'h0, fetch_addr_in[7:0]} + 24'h200;
      else
        fetch_data_out <= ~fetch_data_out;
    end
  end
endmodule

// ---- ivs_top_tb.sv ----
// Self-checking bench for the vector selector top.
// Assumes the core model beside it and the shared map header.
`timescale 1ns/1ps
`include "ivs_map.vh"
`define CHK(n, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
  num_errors = num_errors + 1; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module ivs_top_tb;
  reg          clk_in = 1'b0;        // System clock
  reg          rst_b_in = 1'b0;      // Sync reset, low
  reg  [7:0]   trap_in = 8'h00;      // Trap events
  reg  [117:0] irq_in = 118'h0;      // Source events
  reg          ret_core_in = 1'b0;   // Return pulse
  reg          take = 1'b0;          // Let the core accept once
  reg          wb_cyc_i = 1'b0;      // Bus cycle
  reg          wb_stb_i = 1'b0;      // Bus strobe
  reg          wb_we_i = 1'b0;       // Bus write
  reg  [7:0]   wb_adr_i = 8'h00;     // Bus address
  reg  [31:0]  wb_dat_i = 32'h0;     // Bus write data
  reg  [31:0]  rd;                   // Last read data
  reg  [23:0]  fa;                   // Last slot strobed
  reg  [34:0]  r;                    // Current row
  reg  [31:0]  e;                    // Expected status
  integer      k;                    // Row index
  integer      checked = 0;          // Comparisons made
  integer      num_errors = 0;       // Mismatches seen
  wire         ack_core_in, irq_out, fetch_out, isr_valid_out;
  wire         ret_done_out, wb_ack_o;
  wire [23:0]  fetch_data_in, fetch_addr_out, isr_addr_out, reset_pc_out;
  wire [31:0]  wb_dat_o;
  wire [2:0]   evt = {ret_done_out, isr_valid_out, wb_ack_o};
  // Source, level, table select beside the slot it must strobe
  localparam [34:0] ROWS [0:6] = '{
    {7'h00, 3'h4, 1'b0, 24'h000014}, {7'h00, 3'h1, 1'b1, 24'h000114},
    {7'h01, 3'h3, 1'b0, 24'h000016}, {7'h34, 3'h7, 1'b0, 24'h00007c},
    {7'h35, 3'h2, 1'b1, 24'h00017e}, {7'h75, 3'h5, 1'b0, 24'h0000fe},
    {7'h75, 3'h6, 1'b1, 24'h0001fe}};
  ivs_top u_ivs_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .trap_in(trap_in), .irq_in(irq_in), .ack_core_in(ack_core_in),
    .ret_core_in(ret_core_in), .fetch_data_in(fetch_data_in),
    .irq_out(irq_out), .fetch_addr_out(fetch_addr_out),
    .fetch_out(fetch_out), .isr_addr_out(isr_addr_out),
    .isr_valid_out(isr_valid_out), .reset_pc_out(reset_pc_out),
    .ret_done_out(ret_done_out), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  ivs_core_model u_ivs_core_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .take_in(take), .irq_in(irq_out), .fetch_in(fetch_out),
    .fetch_addr_in(fetch_addr_out), .ack_out(ack_core_in),
    .fetch_data_out(fetch_data_in));
  initial forever #5 clk_in = ~clk_in;
  // Remember the slot of the latest strobe
  always @(posedge clk_in) if (fetch_out === 1'b1) fa <= fetch_addr_out;
  task complete_run;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Bounded wait on one completion bit; running out ends the run
  task await(input integer b);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_in);
        n = n + 1;
      end while (evt[b] !== 1'b1 && n < 60);
      if (evt[b] !== 1'b1) begin
        num_errors = num_errors + 1;
        $display("mismatch wait %0d exp 1 got 0", b);
        complete_run;
      end
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_in);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      await(0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task rdc(input string n, input [7:0] a, input [31:0] x);
    begin
      wb(a, 1'b0, 32'h0);
      `CHK(n, x, rd)
    end
  endtask
  task cfg(input [6:0] s, input [2:0] p);
    begin
      wr(`IVS_OFF_SEL, {25'h0, s});
      wr(`IVS_OFF_PRIO, {29'h0, p});
      wr(`IVS_OFF_ENABLE, 32'h1);
    end
  endtask
  // Cpu level change, then the request line one cycle later
  task lvl(input [2:0] p, input x);
    begin
      wr(`IVS_OFF_CPUPL, {29'h0, p});
      @(posedge clk_in);
      `CHK("irq", x, irq_out)
    end
  endtask
  task poke(input [117:0] u, input [7:0] t);
    begin
      @(posedge clk_in);
      irq_in  <= u;
      trap_in <= t;
      @(posedge clk_in);
      irq_in  <= 118'h0;
      trap_in <= 8'h00;
    end
  endtask
  task enter;
    begin
      @(posedge clk_in);
      take <= 1'b1;
      @(posedge clk_in);
      take <= 1'b0;
      await(1);
    end
  endtask
  task retn;
    begin
      @(posedge clk_in);
      ret_core_in <= 1'b1;
      @(posedge clk_in);
      ret_core_in <= 1'b0;
      await(2);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wr(`IVS_OFF_SEL, 32'h8);
    rdc("prio", `IVS_OFF_PRIO, 32'h4);
    rdc("ctrl", `IVS_OFF_CTRL, 32'h0);
    wr(8'h20, 32'hffffffff);
    rdc("hole", 8'h20, 32'h0);
    `CHK("pc", 24'h000000, reset_pc_out)
    $display("reset test done");
    for (k = 0; k < 7; k = k + 1) begin
      r = ROWS[k];
      wr(`IVS_OFF_CTRL, {16'h0, r[24], 15'h0});
      cfg(r[34:28] + 7'h08, r[27:25]);
      poke(118'h1 << r[34:28], 8'h00);
      enter;
      `CHK("isr", {16'h0, r[7:0]} + 24'h000200, isr_addr_out)
      `CHK("slot", r[23:0], fa)
      e = {20'h0, 1'b0, r[27:25], 1'b0, r[34:28] + 7'h08};
      rdc("status", `IVS_OFF_STATUS, e);
      wr(`IVS_OFF_FLAG, {25'h0, r[34:28]});
      rdc("flag", `IVS_OFF_FLAG, 32'h0);
      `CHK("idle", 1'b0, irq_out)
      wr(`IVS_OFF_ENABLE, 32'h0);
      retn;
      $display("row %0d done", k);
    end
    // Equal levels by index, then a higher level overtakes
    wr(`IVS_OFF_CTRL, 32'h0);
    cfg(7'h0d, 3'h3);
    cfg(7'h11, 3'h3);
    poke(118'h220, 8'h00);
    rdc("tie", `IVS_OFF_STATUS, 32'h0000030d);
    cfg(7'h11, 3'h6);
    rdc("level", `IVS_OFF_STATUS, 32'h00000611);
    lvl(3'h6, 1'b0);
    lvl(3'h5, 1'b1);
    lvl(3'h7, 1'b0);
    $display("level test done");
    // Traps pass the blocking cpu level
    poke(118'h0, 8'h24);
    rdc("trap", `IVS_OFF_STATUS, 32'h00000802);
    enter;
    `CHK("tslot", 24'h000008, fa)
    wr(`IVS_OFF_TRAPS, 32'h4);
    rdc("trap5", `IVS_OFF_STATUS, 32'h00000805);
    wr(`IVS_OFF_TRAPS, 32'h20);
    rdc("traps", `IVS_OFF_TRAPS, 32'h0);
    retn;
    $display("trap test done");
    // Flag sets while disabled, request only once enabled
    wr(`IVS_OFF_FLAG, 32'h5);
    wr(`IVS_OFF_FLAG, 32'h9);
    wr(`IVS_OFF_SEL, 32'hb);
    lvl(3'h0, 1'b0);
    poke(118'h8, 8'h00);
    rdc("flag3", `IVS_OFF_FLAG, 32'h1);
    lvl(3'h0, 1'b0);
    cfg(7'h0b, 3'h1);
    lvl(3'h0, 1'b1);
    $display("enable test done");
    // Reset in mid-run drops the pending request and the table select
    wr(`IVS_OFF_CTRL, 32'h8000);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    `CHK("rst", 1'b0, irq_out)
    rdc("rctrl", `IVS_OFF_CTRL, 32'h0);
    $display("second reset test done");
    complete_run;
  end
endmodule
